// >>> hw/bofd_defs.vh
// What this block does
// - Any channel short-circuit or overload drives the fault summary output high.
// - Unit read with fault reporting on: bit 15 is 0 on fault, else 1.
// - Fault status appears on bit 15 only when fault-to-databus is selected (default).
// - Acknowledge mode selectable, external or automatic; automatic is the default.
// - Automatic mode does not latch the fault; status returns once fault clears.
// - Automatic mode re-enables a channel by itself when its short is removed.
// - External mode keeps a faulted channel off until fault gone and ack high.
// - A short-circuit indicator output mirrors the fault summary.
// - Two indicators show the release input and the acknowledge input.
// - Outputs are set only by word or byte writes; no output read-back.
// - Respond only to top bits 111 plus matching unit address; lane picks group.
// - Release high enables the channels; release low forces all channels off.
// - Address-match flag pulses for one cycle after a bus request whose address comparison succeeds.
`ifndef BOFD_DEFS_VH
`define BOFD_DEFS_VH

// ==========================================================
// Address decode
`define BOFD_CODE_HI 15
`define BOFD_CODE_LO 13
`define BOFD_CODE_VAL 3'h7
`define BOFD_UNIT_HI 12
`define BOFD_UNIT_LO 5
`define BOFD_OFS_HI 4
`define BOFD_OFS_LO 0

// ==========================================================
// Register offsets inside the unit
`define BOFD_OFS_OUTPUT 5'h00
`define BOFD_OFS_CONFIG 5'h04
`define BOFD_OFS_STATUS 5'h08
`define BOFD_OFS_IRQ_STAT 5'h0c
`define BOFD_OFS_IRQ_MASK 5'h10

// ==========================================================
// Fields
`define BOFD_FAULT_BIT 15
`define BOFD_CFG_ACK_MODE 0
`define BOFD_CFG_FAULT_BUS 1
`define BOFD_ST_FAULT 0
`define BOFD_ST_RELEASE 1
`define BOFD_ST_ACK 2
`define BOFD_IRQ_FAULT 0
`define BOFD_IRQ_RELEASE_LOST 1
`define BOFD_IRQ_W 2

// ==========================================================
// Reset values
`define BOFD_RST_OUTPUT 16'h0000
`define BOFD_RST_ACK_MODE 1'b0
`define BOFD_RST_FAULT_BUS 1'b1
`define BOFD_RST_IRQ 2'h0

`endif

// >>> hw/bofd_sync.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Three-stage pin synchroniser with agreement filter
module bofd_sync #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input wire i_clock,
  input wire i_srst,
  // Pins and clean levels
  input wire [WIDTH-1:0] i_pin,
  output reg [WIDTH-1:0] o_level
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // The first stage feeds only the second, so metastability never reaches logic.
      always @(posedge i_clock) begin
        if (i_srst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          o_level[g] <= 1'b0;
        end else begin
          s1_q[g] <= i_pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            o_level[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

endmodule // bofd_sync
`default_nettype wire

// >>> hw/bofd_top.v
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bofd_defs.vh"
// ==========================================================
// Binary output unit with fault diagnosis, Avalon-MM slave
module bofd_top #(
  parameter CHANNELS = 16
) (
  // Clock and reset
  input wire i_clock,
  input wire i_srst,
  // Avalon-MM slave
  input wire [15:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // Unit address switches
  input wire [7:0] i_unit_address,
  // Field pins
  input wire [CHANNELS-1:0] i_chan_fault,
  input wire i_release,
  input wire i_ack,
  output wire [CHANNELS-1:0] o_chan,
  output wire o_fault_summary,
  output wire o_short_led,
  output wire o_release_led,
  output wire o_ack_led,
  // Diagnostics and interrupt
  output reg o_address_match_flag,
  output wire o_irq
);

  // ========================================================
  // Pin synchronisation
  wire [CHANNELS+1:0] pins_s;
  wire [CHANNELS-1:0] fault_live;
  wire release_s;
  wire ack_s;

  bofd_sync #(
    .WIDTH(CHANNELS + 2)
  ) u_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_pin({i_ack, i_release, i_chan_fault}),
    .o_level(pins_s)
  );

  assign fault_live = pins_s[CHANNELS-1:0];
  assign release_s = pins_s[CHANNELS];
  assign ack_s = pins_s[CHANNELS+1];

  // ========================================================
  // Bus decode
  reg ack_q;
  wire req;
  wire unit_hit;
  wire [4:0] ofs;

  assign req = i_avs_read | i_avs_write;
  assign unit_hit = (i_avs_address[`BOFD_CODE_HI:`BOFD_CODE_LO] == `BOFD_CODE_VAL) &&
                    (i_avs_address[`BOFD_UNIT_HI:`BOFD_UNIT_LO] == i_unit_address);
  assign ofs = i_avs_address[`BOFD_OFS_HI:`BOFD_OFS_LO];
  // Every request, mapped or not, is answered one cycle later so the master never hangs.
  assign o_avs_waitrequest = req & ~ack_q;

  wire take;
  wire wr_take;
  assign take = req & ~ack_q;
  assign wr_take = i_avs_write & ~ack_q & unit_hit;

  // ========================================================
  // Registers
  reg [CHANNELS-1:0] out_q;
  reg ack_mode_select_q;
  reg fault_to_databus_select_q;
  reg [`BOFD_IRQ_W-1:0] irq_stat_q;
  reg [`BOFD_IRQ_W-1:0] irq_mask_q;
  reg [CHANNELS-1:0] chan_off_q;
  reg summary_prev_q;
  reg release_prev_q;
  wire summary;
  wire [`BOFD_IRQ_W-1:0] irq_set;

  always @(posedge i_clock) begin
    if (i_srst) begin
      ack_q <= 1'b0;
      o_address_match_flag <= 1'b0;
      out_q <= `BOFD_RST_OUTPUT;
      ack_mode_select_q <= `BOFD_RST_ACK_MODE;
      fault_to_databus_select_q <= `BOFD_RST_FAULT_BUS;
      irq_mask_q <= `BOFD_RST_IRQ;
    end else begin
      ack_q <= take;
      o_address_match_flag <= take & unit_hit;
      if (wr_take) begin
        if (ofs == `BOFD_OFS_OUTPUT) begin
          // Lane 0 reaches channels 0 to 7, lane 1 channels 8 to 15; both is a word write.
          if (i_avs_byteenable[0]) begin
            out_q[7:0] <= i_avs_writedata[7:0];
          end
          if (i_avs_byteenable[1]) begin
            out_q[15:8] <= i_avs_writedata[15:8];
          end
        end else if (ofs == `BOFD_OFS_CONFIG) begin
          if (i_avs_byteenable[0]) begin
            ack_mode_select_q <= i_avs_writedata[`BOFD_CFG_ACK_MODE];
            fault_to_databus_select_q <= i_avs_writedata[`BOFD_CFG_FAULT_BUS];
          end
        end else if (ofs == `BOFD_OFS_IRQ_MASK) begin
          if (i_avs_byteenable[0]) begin
            irq_mask_q <= i_avs_writedata[`BOFD_IRQ_W-1:0];
          end
        end
      end
    end
  end

  // ========================================================
  // Read path
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (take & i_avs_read) begin
      o_avs_readdata <= 32'h0000_0000;
      if (unit_hit) begin
        if (ofs == `BOFD_OFS_OUTPUT) begin
          // Output values are never read back; only the fault bit shows here.
          if (fault_to_databus_select_q) begin
            o_avs_readdata[`BOFD_FAULT_BIT] <= ~summary;
          end
        end else if (ofs == `BOFD_OFS_CONFIG) begin
          o_avs_readdata[`BOFD_CFG_ACK_MODE] <= ack_mode_select_q;
          o_avs_readdata[`BOFD_CFG_FAULT_BUS] <= fault_to_databus_select_q;
        end else if (ofs == `BOFD_OFS_STATUS) begin
          o_avs_readdata[`BOFD_ST_FAULT] <= summary;
          o_avs_readdata[`BOFD_ST_RELEASE] <= release_s;
          o_avs_readdata[`BOFD_ST_ACK] <= ack_s;
          o_avs_readdata[31:16] <= chan_off_q;
        end else if (ofs == `BOFD_OFS_IRQ_STAT) begin
          o_avs_readdata[`BOFD_IRQ_W-1:0] <= irq_stat_q;
        end else if (ofs == `BOFD_OFS_IRQ_MASK) begin
          o_avs_readdata[`BOFD_IRQ_W-1:0] <= irq_mask_q;
        end
      end
    end
  end

  // ========================================================
  // Fault handling per channel
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c = c + 1) begin : g_chan
      always @(posedge i_clock) begin
        if (i_srst) begin
          chan_off_q[c] <= 1'b0;
        end else if (!ack_mode_select_q) begin
          chan_off_q[c] <= fault_live[c];
        end else if (fault_live[c]) begin
          chan_off_q[c] <= 1'b1;
        end else if (ack_s) begin
          chan_off_q[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // In external mode the stored disable also holds the summary until acknowledged.
  assign summary = ack_mode_select_q ? (|chan_off_q) : (|fault_live);
  assign o_fault_summary = summary;
  assign o_short_led = summary;
  assign o_release_led = release_s;
  assign o_ack_led = ack_s;
  assign o_chan = out_q & ~chan_off_q & {CHANNELS{release_s}};

  // ========================================================
  // Interrupts
  assign irq_set[`BOFD_IRQ_FAULT] = summary & ~summary_prev_q;
  assign irq_set[`BOFD_IRQ_RELEASE_LOST] = release_prev_q & ~release_s;

  wire [`BOFD_IRQ_W-1:0] irq_clr;
  assign irq_clr = (wr_take && (ofs == `BOFD_OFS_IRQ_STAT) && i_avs_byteenable[0]) ?
                   i_avs_writedata[`BOFD_IRQ_W-1:0] : {`BOFD_IRQ_W{1'b0}};

  always @(posedge i_clock) begin
    if (i_srst) begin
      irq_stat_q <= `BOFD_RST_IRQ;
      summary_prev_q <= 1'b0;
      release_prev_q <= 1'b0;
    end else begin
      summary_prev_q <= summary;
      release_prev_q <= release_s;
      // A new event in the clearing cycle wins over the clear.
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

endmodule // bofd_top
`default_nettype wire

// >>> bench/bofd_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module bofd_top_props #(
  parameter CHANNELS = 16
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [15:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [7:0] i_unit_address,
  input wire logic [CHANNELS-1:0] i_chan_fault,
  input wire logic i_release,
  input wire logic i_ack,
  input wire logic [CHANNELS-1:0] o_chan,
  input wire logic o_fault_summary,
  input wire logic o_short_led,
  input wire logic o_release_led,
  input wire logic o_ack_led,
  input wire logic o_address_match_flag
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_hit;
    s_taken ##0 (i_avs_address[15:13] == 3'h7 && i_avs_address[12:5] == i_unit_address
      && i_avs_address[4:0] == 5'h00);
  endsequence
  chk_wait_state: assert property (s_taken |=> !o_avs_waitrequest) else $error("no answer");
  chk_idle_bus: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("wait while idle");
  chk_match_hit: assert property (s_hit |-> ##[1:2] o_address_match_flag) else $error("no match");
  chk_match_pulse: assert property (o_address_match_flag |=> !o_address_match_flag)
    else $error("match too long");
  chk_summary_led: assert property (o_short_led == o_fault_summary) else $error("led differs");
  chk_fault_sum: assert property ((|i_chan_fault)[*8] |-> o_fault_summary)
    else $error("fault not summarised");
  chk_fault_off: assert property ($stable(i_chan_fault)[*8] |-> (o_chan & i_chan_fault) == '0)
    else $error("faulted channel on");
  chk_release_off: assert property ((!i_release)[*8] |-> o_chan == '0)
    else $error("channel on without release");
  chk_release_led: assert property ($stable(i_release)[*8] |-> o_release_led == i_release)
    else $error("release led wrong");
  chk_ack_led: assert property ($stable(i_ack)[*8] |-> o_ack_led == i_ack)
    else $error("ack led wrong");
endmodule // bofd_top_props
bind bofd_top bofd_top_props #(.CHANNELS(CHANNELS)) i_props (.i_clock, .i_srst, .i_avs_address,
  .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_unit_address, .i_chan_fault, .i_release,
  .i_ack, .o_chan, .o_fault_summary, .o_short_led, .o_release_led, .o_ack_led,
  .o_address_match_flag);
`default_nettype wire

// >>> bench/bofd_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus master model
module bofd_master (
  input wire logic i_clock,
  input wire logic i_avs_waitrequest,
  input wire logic [31:0] i_avs_readdata,
  output logic o_read,
  output logic o_write,
  output logic [15:0] o_address,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  initial begin
    o_read = 1'b0;
    o_write = 1'b0;
    o_address = 16'h0000;
    o_writedata = 32'h0000_0000;
    o_byteenable = 4'h0;
  end
  // Idle address and write-data lines carry inverted values so that stale data is never mistaken for an answer.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    o_read <= !w;
    o_write <= w;
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= be;
    // Only the bench watchdog may end this wait; the slave sets the pace.
    do begin
      @(posedge i_clock);
    end while (i_avs_waitrequest !== 1'b0);
    q = i_avs_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    o_address <= ~a;
    o_writedata <= ~d;
  endtask
endmodule // bofd_master
`default_nettype wire

// >>> bench/bofd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bofd_defs.vh"
// ==========
// Testbench
module bofd_top_tb;
  logic clk, srst, rd, wr, wreq, fs, sl, rl, al, mf, irq, rel, ack;
  logic [15:0] addr, chf, chan;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [35:0] rows [5] = '{36'h3_a5c3_a5c3, 36'h1_ff3c_a53c, 36'h2_0f00_0f3c,
                             36'h0_ffff_0f3c, 36'h3_ffff_ffff};
  bofd_top i_dut (.i_clock(clk), .i_srst(srst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_unit_address(8'h21), .i_chan_fault(chf), .i_release(rel),
    .i_ack(ack), .o_chan(chan), .o_fault_summary(fs), .o_short_led(sl), .o_release_led(rl),
    .o_ack_led(al), .o_address_match_flag(mf), .o_irq(irq));
  bofd_master i_bus (.i_clock(clk), .i_avs_waitrequest(wreq), .i_avs_readdata(rdata),
    .o_read(rd), .o_write(wr), .o_address(addr), .o_writedata(wdata), .o_byteenable(be));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bw(input logic [4:0] o, input logic [31:0] d, input logic [3:0] b);
    i_bus.xfer(1'b1, {11'h721, o}, d, b, q);
    cyc(1);
  endtask
  task automatic br(input logic [4:0] o, input logic [31:0] e);
    i_bus.xfer(1'b0, {11'h721, o}, 32'h0000_0000, 4'hf, q);
    cyc(1);
    chk(q, e);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    rel = 1'b1;
    ack = 1'b0;
    chf = 16'h0000;
    cyc(2);
    srst <= 1'b0;
    cyc(9);
    chk(chan, 32'h0000_0000);
    br(`BOFD_OFS_CONFIG, 32'h0000_0002);
    for (int i = 0; i < 5; i++) begin
      bw(`BOFD_OFS_OUTPUT, {16'h0000, rows[i][31:16]}, rows[i][35:32]);
      chk(chan, rows[i][15:0]);
    end
    br(`BOFD_OFS_OUTPUT, 32'h0000_8000);
    br(5'h1c, 32'h0000_0000);
    i_bus.xfer(1'b1, 16'he440, 32'h0000_0000, 4'hf, q);
    cyc(1);
    chk(chan, 32'h0000_ffff);
    rel <= 1'b0;
    cyc(8);
    chk(chan, 32'h0000_0000);
    chk(rl, 32'h0000_0000);
    rel <= 1'b1;
    chf <= 16'h0008;
    cyc(8);
    chk(chan, 32'h0000_fff7);
    chk({fs, sl}, 32'h0000_0003);
    br(`BOFD_OFS_OUTPUT, 32'h0000_0000);
    chf <= 16'h0000;
    cyc(8);
    chk(chan, 32'h0000_ffff);
    br(`BOFD_OFS_OUTPUT, 32'h0000_8000);
    bw(`BOFD_OFS_CONFIG, 32'h0000_0000, 4'hf);
    br(`BOFD_OFS_OUTPUT, 32'h0000_0000);
    bw(`BOFD_OFS_CONFIG, 32'h0000_0003, 4'hf);
    chf <= 16'h0008;
    cyc(8);
    chf <= 16'h0000;
    cyc(8);
    chk({fs, chan}, 32'h0001_fff7);
    br(`BOFD_OFS_STATUS, 32'h0008_0003);
    ack <= 1'b1;
    cyc(8);
    chk({al, chan}, 32'h0001_ffff);
    ack <= 1'b0;
    chk(irq, 32'h0000_0000);
    bw(`BOFD_OFS_IRQ_MASK, 32'h0000_0003, 4'hf);
    chk(irq, 32'h0000_0001);
    br(`BOFD_OFS_IRQ_STAT, 32'h0000_0003);
    bw(`BOFD_OFS_IRQ_STAT, 32'h0000_0003, 4'hf);
    chk(irq, 32'h0000_0000);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(9);
    chk(chan, 32'h0000_0000);
    give_verdict();
  end
endmodule // bofd_top_tb
`default_nettype wire
